/* File: hdl/ihb_pkg.sv */
`default_nettype none
package ihb_pkg;
	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_NS         = 5;
	// Synchroniser, state update, fetch and release: off every read and write maximum
	localparam int SYNC_LAG       = 5;
	localparam int T_RD8_NS       = 235;
	localparam int T_RD16_NS      = 315;
	localparam int T_RD8P8_NS     = 435;
	localparam int T_RD8P16_NS    = 495;
	localparam int T_RD16P8_NS    = 515;
	localparam int T_RD16P16_NS   = 575;
	localparam int T_DLY_NS       = 20;
	localparam int T_WR8_NS       = 200;
	localparam int T_WR16_NS      = 280;
	localparam int T_DVB_NS       = 15;
	localparam int T_GAP_NS       = 13;
	localparam int T_STRB_NS      = 32;
	localparam int T_WORST_NS     = 595;

	localparam logic [7:0] RD8_C     = 8'(T_RD8_NS / CLK_NS - SYNC_LAG);
	localparam logic [7:0] RD16_C    = 8'(T_RD16_NS / CLK_NS - SYNC_LAG);
	localparam logic [7:0] RD8P8_C   = 8'(T_RD8P8_NS / CLK_NS - SYNC_LAG);
	localparam logic [7:0] RD8P16_C  = 8'(T_RD8P16_NS / CLK_NS - SYNC_LAG);
	localparam logic [7:0] RD16P8_C  = 8'(T_RD16P8_NS / CLK_NS - SYNC_LAG);
	localparam logic [7:0] RD16P16_C = 8'(T_RD16P16_NS / CLK_NS - SYNC_LAG);
	localparam logic [7:0] DLY_C     = 8'(T_DLY_NS / CLK_NS);
	localparam logic [7:0] WR8_C     = 8'(T_WR8_NS / CLK_NS - SYNC_LAG);
	localparam logic [7:0] WR16_C    = 8'(T_WR16_NS / CLK_NS - SYNC_LAG);
	localparam logic [7:0] DVB_C     = 8'((T_DVB_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] GAP_C     = 8'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] GUARD_C   = 8'((T_STRB_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] WORST_C   = 8'((T_WORST_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] ONE_C     = 8'h01;

	// ------------------------------------------------------------
	// Polarity vector positions, widths
	// ------------------------------------------------------------
	localparam int POL_CS   = 0;
	localparam int POL_A    = 1;
	localparam int POL_B    = 2;
	localparam int POL_WAIT = 3;
	localparam int AW       = 16;
	localparam int DW       = 16;

	// ------------------------------------------------------------
	// Controller registers
	// ------------------------------------------------------------
	localparam logic [3:0]  REG_CTRL   = 4'h0;
	localparam logic [3:0]  REG_CMD    = 4'h4;
	localparam logic [3:0]  REG_WDATA  = 4'h8;
	localparam logic [3:0]  REG_STATUS = 4'hc;
	localparam int CTRL_SEP   = 0;
	localparam int CTRL_WEN   = 1;
	localparam int CTRL_POL   = 2;
	localparam logic [5:0]  CTRL_RST   = 6'h00;
	localparam int CMD_RD     = 16;
	localparam int CMD_WIDE   = 17;
	localparam int ST_BUSY    = 0;
	localparam int ST_DONE    = 1;
	localparam int ST_RDATA   = 16;
	localparam logic [1:0]  RESP_OK    = 2'h0;
	localparam logic [1:0]  RESP_ERR   = 2'h2;

	typedef enum logic [6:0] {
		D_IDLE = 7'b0000001,
		D_RD   = 7'b0000010,
		D_RDH  = 7'b0000100,
		D_PW   = 7'b0001000,
		D_WH   = 7'b0010000,
		D_NP   = 7'b0100000,
		D_NPH  = 7'b1000000
	} ihb_dst_type;

	typedef enum logic [4:0] {
		H_IDLE  = 5'b00001,
		H_SETUP = 5'b00010,
		H_STRB  = 5'b00100,
		H_REL   = 5'b01000,
		H_GAP   = 5'b10000
	} ihb_hst_type;

	// Active-level lines a, b to {read strobe, write strobe}
	function automatic logic [1:0] ihb_strobes(input logic a, input logic b,
			input logic sep);
		ihb_strobes = sep ? {a, b} : {b & a, b & ~a};
	endfunction
endpackage
`default_nettype wire

/* File: hdl/ihb_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ihb_if;
	logic          cs;
	logic          rd_dir;
	logic          wr_en;
	logic          wide;
	logic [15:0]   addr;
	logic [15:0]   h_dout;
	logic          h_doe;
	logic [15:0]   d_dout;
	logic          d_doe;
	logic          wait_o;
	logic          wait_oe;
	logic [15:0]   data;
	logic          wait_lvl;

	// Wire resolution; an undriven bus reads zero
	assign data     = h_doe ? h_dout : (d_doe ? d_dout : 16'h0000);
	assign wait_lvl = wait_oe ? wait_o : 1'b0;

	modport host (output cs, rd_dir, wr_en, wide, addr, h_dout, h_doe,
		input data, wait_lvl);
	modport dev (input cs, rd_dir, wr_en, wide, addr, data,
		output d_dout, d_doe, wait_o, wait_oe);
endinterface
`default_nettype wire

/* File: hdl/ihb_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ihb_sync #(
	parameter int W = 1
) (
	input  wire logic           i_clk,
	input  wire logic           i_rst,
	input  wire logic [W-1:0]   i_d,
	output logic      [W-1:0]   o_q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} ihb_sync_type;

	ihb_sync_type r_ff;
	ihb_sync_type nxt_r;

	always_comb begin
		nxt_r.meta = i_d;
		nxt_r.q    = r_ff.meta;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign o_q = r_ff.q;
endmodule
`default_nettype wire

/* File: hdl/ihb_dev.sv */
// Notes on behaviour
// - Stall flag marks read data ready
// - Without flag, host holds worst-case time
// - Flag driven only while selected
// - Read strobe raises flag, also with select
// - Read cycle from strobe assert to release
// - Host never moves select during strobe
// - Write cycle from strobe assert to release
// - Compatibility mode keeps flag acknowledging
// - Read release 235/315 ns, none pending
// - Read release longer behind pending write
// - Delayed option adds twenty nanoseconds
// - Normal: data valid by flag release
// - Delayed: data valid 15 ns earlier
// - Posted write starts active if pending
// - Host holds write strobe until release
// - Posted write: flag active on release
// - Select released with strobe drops flag
// - Posted behind pending: 200/280 ns
// - Non-posted: flag rises with strobe
// - Non-posted release 200/280 ns
// - Each line has its own polarity
`timescale 1ns/1ps
`default_nettype none
module ihb_dev
	import ihb_pkg::*;
(
	input  wire logic          I_CLK,
	input  wire logic          I_RST,
	ihb_if.dev                 BUS,
	input  wire logic          I_MM_MODE,
	input  wire logic          I_WAIT_EN,
	input  wire logic          I_DELAYED,
	input  wire logic          I_POSTED,
	input  wire logic          I_SEP_SIG,
	input  wire logic [3:0]    I_POL,
	output logic               O_WR_STB,
	output logic [15:0]        O_WR_ADDR,
	output logic [15:0]        O_WR_DATA,
	output logic               O_WR_WIDE,
	output logic               O_RD_STB,
	output logic [15:0]        O_RD_ADDR,
	output logic               O_RD_WIDE,
	input  wire logic [15:0]   I_RD_DATA,
	output logic               O_PENDING
);
	import ihb_pkg::*;

	typedef struct packed {
		ihb_dst_type  st;
		logic [7:0]   cnt;
		logic [7:0]   pw_cnt;
		logic         pw_wide;
		logic [15:0]  pw_addr;
		logic [15:0]  pw_data;
		logic         wr_stb;
		logic [15:0]  wr_addr;
		logic [15:0]  wr_data;
		logic         wr_wide;
		logic [15:0]  acc_addr;
		logic         acc_wide;
		logic [15:0]  wd;
		logic [15:0]  dout;
		logic         rdv;
		logic         wait_act;
	} ihb_dev_type;

	ihb_dev_type r_ff;
	ihb_dev_type nxt_r;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [35:0]   pins_s;
	logic          s_cs;
	logic          s_a;
	logic          s_b;
	logic          s_wide;
	logic [15:0]   s_addr;
	logic [15:0]   s_data;
	logic          cs_a;
	logic          rd_s;
	logic          wr_s;
	logic          pw_busy;
	logic          rd_req;
	logic [7:0]    hold;
	logic          lead;

	ihb_sync #(.W(36)) u_sync (
		.i_clk (I_CLK),
		.i_rst (I_RST),
		.i_d   ({BUS.cs, BUS.rd_dir, BUS.wr_en, BUS.wide, BUS.addr,
			BUS.data}),
		.o_q   (pins_s)
	);

	assign {s_cs, s_a, s_b, s_wide, s_addr, s_data} = pins_s;
	assign cs_a = (s_cs == I_POL[POL_CS]);
	assign {rd_s, wr_s} = ihb_strobes(s_a == I_POL[POL_A],
		s_b == I_POL[POL_B], I_SEP_SIG);
	assign pw_busy = (r_ff.pw_cnt != 8'h00);
	// Delayed option pulls data ahead of the flag release
	assign hold = I_DELAYED ? DVB_C : 8'h00;

	// ------------------------------------------------------------
	// Read latency by width and pending write
	// ------------------------------------------------------------
	function automatic logic [7:0] rd_lat(input logic w16, input logic pb,
			input logic p16);
		if (!pb) begin
			rd_lat = w16 ? RD16_C : RD8_C;
		end else if (w16) begin
			rd_lat = p16 ? RD16P16_C : RD16P8_C;
		end else begin
			rd_lat = p16 ? RD8P16_C : RD8P8_C;
		end
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_r        = r_ff;
		nxt_r.wr_stb = 1'b0;
		rd_req       = 1'b0;
		// Pending posted write drains in the background
		if (pw_busy) begin
			nxt_r.pw_cnt = r_ff.pw_cnt - ONE_C;
			if (r_ff.pw_cnt == ONE_C) begin
				nxt_r.wr_stb  = 1'b1;
				nxt_r.wr_addr = r_ff.pw_addr;
				nxt_r.wr_data = r_ff.pw_data;
				nxt_r.wr_wide = r_ff.pw_wide;
			end
		end
		unique case (r_ff.st)
			D_IDLE: begin
				// Pending indication persists after a posted write
				nxt_r.wait_act = I_MM_MODE & pw_busy;
				nxt_r.acc_addr = s_addr;
				nxt_r.acc_wide = s_wide;
				nxt_r.rdv      = 1'b0;
				if (cs_a && rd_s) begin
					nxt_r.st       = D_RD;
					nxt_r.wait_act = I_MM_MODE;
					nxt_r.cnt      = 8'h00;
					if (I_MM_MODE) begin
						nxt_r.cnt = rd_lat(s_wide, pw_busy, r_ff.pw_wide)
							+ (I_DELAYED ? DLY_C : 8'h00);
					end
				end else if (cs_a && wr_s) begin
					if (I_POSTED || !I_MM_MODE) begin
						nxt_r.wait_act = I_MM_MODE & pw_busy;
						nxt_r.st = (I_MM_MODE && pw_busy) ? D_PW : D_WH;
					end else begin
						nxt_r.st       = D_NP;
						nxt_r.wait_act = 1'b1;
						nxt_r.cnt      = s_wide ? WR16_C : WR8_C;
					end
				end
			end
			D_RD: begin
				if (r_ff.cnt != 8'h00) begin
					nxt_r.cnt = r_ff.cnt - ONE_C;
				end
				if (!rd_s) begin
					nxt_r.st       = D_IDLE;
					nxt_r.wait_act = 1'b0;
				end else if (!r_ff.rdv && !pw_busy && r_ff.cnt <= hold) begin
					// Fetch only once the pending write has landed
					rd_req     = 1'b1;
					nxt_r.dout = I_RD_DATA;
					nxt_r.rdv  = 1'b1;
					if (r_ff.cnt < hold) begin
						nxt_r.cnt = hold;
					end
				end else if (r_ff.rdv && r_ff.cnt == 8'h00) begin
					nxt_r.wait_act = 1'b0;
					nxt_r.st       = D_RDH;
				end
			end
			D_RDH: begin
				if (!rd_s) begin
					nxt_r.st = D_IDLE;
				end
			end
			D_PW: begin
				nxt_r.wd = s_data;
				if (!pw_busy) begin
					nxt_r.wait_act = 1'b0;
					nxt_r.st       = D_WH;
				end
			end
			D_WH: begin
				if (wr_s) begin
					nxt_r.wd = s_data;
				end else begin
					// Accepted write now pending internally
					nxt_r.pw_cnt   = I_MM_MODE ?
						(r_ff.acc_wide ? WR16_C : WR8_C) : ONE_C;
					nxt_r.pw_addr  = r_ff.acc_addr;
					nxt_r.pw_data  = r_ff.wd;
					nxt_r.pw_wide  = r_ff.acc_wide;
					nxt_r.wait_act = I_MM_MODE;
					nxt_r.st       = D_IDLE;
				end
			end
			D_NP: begin
				nxt_r.wd = s_data;
				if (pw_busy) begin
					nxt_r.cnt = r_ff.cnt;
				end else if (r_ff.cnt != 8'h00) begin
					nxt_r.cnt = r_ff.cnt - ONE_C;
				end else begin
					nxt_r.wr_stb   = 1'b1;
					nxt_r.wr_addr  = r_ff.acc_addr;
					nxt_r.wr_data  = r_ff.wd;
					nxt_r.wr_wide  = r_ff.acc_wide;
					nxt_r.wait_act = 1'b0;
					nxt_r.st       = D_NPH;
				end
			end
			D_NPH: begin
				if (!wr_s) begin
					nxt_r.st = D_IDLE;
				end
			end
			default: begin
				nxt_r.st = D_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			r_ff    <= '0;
			r_ff.st <= D_IDLE;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Enable follows select, so a joint release drops the flag too
	assign BUS.wait_oe = I_WAIT_EN & cs_a;
	// Select and strobe seen together: no inactive cycle before the state
	assign lead = I_MM_MODE & (r_ff.st == D_IDLE) & cs_a
		& (rd_s | (wr_s & ~I_POSTED));
	assign BUS.wait_o  = (r_ff.wait_act | lead) ? I_POL[POL_WAIT]
		: ~I_POL[POL_WAIT];
	assign BUS.d_dout  = r_ff.dout;
	assign BUS.d_doe   = cs_a & ((r_ff.st == D_RD) | (r_ff.st == D_RDH));
	assign O_WR_STB    = r_ff.wr_stb;
	assign O_WR_ADDR   = r_ff.wr_addr;
	assign O_WR_DATA   = r_ff.wr_data;
	assign O_WR_WIDE   = r_ff.wr_wide;
	assign O_RD_STB    = rd_req;
	assign O_RD_ADDR   = r_ff.acc_addr;
	assign O_RD_WIDE   = r_ff.acc_wide;
	assign O_PENDING   = pw_busy;
endmodule
`default_nettype wire

/* File: hdl/ihb_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ihb_host
	import ihb_pkg::*;
(
	input  wire logic          I_CLK,
	input  wire logic          I_RST,
	ihb_if.host                BUS,
	input  wire logic [31:0]   I_AWADDR,
	input  wire logic          I_AWVALID,
	output logic               O_AWREADY,
	input  wire logic [31:0]   I_WDATA,
	input  wire logic [3:0]    I_WSTRB,
	input  wire logic          I_WVALID,
	output logic               O_WREADY,
	output logic [1:0]         O_BRESP,
	output logic               O_BVALID,
	input  wire logic          I_BREADY,
	input  wire logic [31:0]   I_ARADDR,
	input  wire logic          I_ARVALID,
	output logic               O_ARREADY,
	output logic [31:0]        O_RDATA,
	output logic [1:0]         O_RRESP,
	output logic               O_RVALID,
	input  wire logic          I_RREADY
);
	import ihb_pkg::*;

	typedef struct packed {
		ihb_hst_type  st;
		logic [7:0]   cnt;
		logic [5:0]   ctrl;
		logic [15:0]  addr;
		logic         rd;
		logic         wide;
		logic [15:0]  wdata;
		logic [15:0]  rdata;
		logic         done;
		logic         cs;
		logic         strb;
		logic         doe;
		logic         aw_got;
		logic         w_got;
		logic [3:0]   aw_addr;
		logic [31:0]  w_data;
		logic [3:0]   w_strb;
		logic         bvalid;
		logic [1:0]   bresp;
		logic         rvalid;
		logic [31:0]  rbus;
		logic [1:0]   rresp;
	} ihb_host_type;

	ihb_host_type r_ff;
	ihb_host_type nxt_r;
	logic [16:0]  sync_q;
	logic         wait_act;
	logic [3:0]   pol;
	logic         sep;

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			old[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
		merge = old;
	endfunction

	ihb_sync #(.W(17)) u_sync (
		.i_clk (I_CLK),
		.i_rst (I_RST),
		.i_d   ({BUS.wait_lvl, BUS.data}),
		.o_q   (sync_q)
	);

	assign pol      = r_ff.ctrl[CTRL_POL +: 4];
	assign sep      = r_ff.ctrl[CTRL_SEP];
	assign wait_act = (sync_q[16] == pol[POL_WAIT]);

	// ------------------------------------------------------------
	// Register bus and bus sequencer
	// ------------------------------------------------------------
	always_comb begin
		logic [31:0] m;
		m     = 32'h0;
		nxt_r = r_ff;
		if (I_AWVALID && !r_ff.aw_got) begin
			nxt_r.aw_got  = 1'b1;
			nxt_r.aw_addr = I_AWADDR[3:0];
		end
		if (I_WVALID && !r_ff.w_got) begin
			nxt_r.w_got  = 1'b1;
			nxt_r.w_data = I_WDATA;
			nxt_r.w_strb = I_WSTRB;
		end
		if (r_ff.bvalid && I_BREADY) begin
			nxt_r.bvalid = 1'b0;
		end
		if (r_ff.aw_got && r_ff.w_got && !r_ff.bvalid) begin
			nxt_r.aw_got = 1'b0;
			nxt_r.w_got  = 1'b0;
			nxt_r.bvalid = 1'b1;
			nxt_r.bresp  = RESP_OK;
			unique case (r_ff.aw_addr)
				REG_CTRL: begin
					m = merge({26'h0, r_ff.ctrl}, r_ff.w_data, r_ff.w_strb);
					nxt_r.ctrl = m[5:0];
				end
				REG_CMD: begin
					m = merge({14'h0, r_ff.wide, r_ff.rd, r_ff.addr},
						r_ff.w_data, r_ff.w_strb);
					// A command while busy is dropped
					if (r_ff.st == H_IDLE) begin
						nxt_r.addr = m[15:0];
						nxt_r.rd   = m[CMD_RD];
						nxt_r.wide = m[CMD_WIDE];
						nxt_r.done = 1'b0;
						nxt_r.st   = H_SETUP;
					end
				end
				REG_WDATA: begin
					m = merge({16'h0, r_ff.wdata}, r_ff.w_data, r_ff.w_strb);
					nxt_r.wdata = m[15:0];
				end
				REG_STATUS: begin
				end
				default: begin
					nxt_r.bresp = RESP_ERR;
				end
			endcase
		end
		if (r_ff.rvalid && I_RREADY) begin
			nxt_r.rvalid = 1'b0;
		end
		if (I_ARVALID && !r_ff.rvalid) begin
			nxt_r.rvalid = 1'b1;
			nxt_r.rresp  = RESP_OK;
			nxt_r.rbus   = 32'h0;
			unique case (I_ARADDR[3:0])
				REG_CTRL:   nxt_r.rbus = {26'h0, r_ff.ctrl};
				REG_CMD:    nxt_r.rbus = {14'h0, r_ff.wide, r_ff.rd,
					r_ff.addr};
				REG_WDATA:  nxt_r.rbus = {16'h0, r_ff.wdata};
				REG_STATUS: nxt_r.rbus = {r_ff.rdata, 14'h0, r_ff.done,
					r_ff.st != H_IDLE};
				default:    nxt_r.rresp = RESP_ERR;
			endcase
		end
		unique case (r_ff.st)
			H_IDLE: begin
			end
			H_SETUP: begin
				nxt_r.cs   = 1'b1;
				nxt_r.doe  = ~r_ff.rd;
				nxt_r.strb = 1'b1;
				nxt_r.cnt  = r_ff.ctrl[CTRL_WEN] ? GUARD_C : WORST_C;
				nxt_r.st   = H_STRB;
			end
			H_STRB: begin
				if (r_ff.cnt != 8'h00) begin
					nxt_r.cnt = r_ff.cnt - ONE_C;
				end else if (!r_ff.ctrl[CTRL_WEN] || !wait_act) begin
					// Strobe held until the stall flag clears, or for the worst-case count with the flag off
					nxt_r.rdata = sync_q[15:0];
					nxt_r.strb  = 1'b0;
					nxt_r.st    = H_REL;
				end
			end
			H_REL: begin
				// Select moves only with the strobe inactive
				nxt_r.cs  = 1'b0;
				nxt_r.doe = 1'b0;
				nxt_r.cnt = GAP_C;
				nxt_r.st  = H_GAP;
			end
			H_GAP: begin
				if (r_ff.cnt != 8'h00) begin
					nxt_r.cnt = r_ff.cnt - ONE_C;
				end else begin
					nxt_r.done = 1'b1;
					nxt_r.st   = H_IDLE;
				end
			end
			default: begin
				nxt_r.st = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			r_ff      <= '0;
			r_ff.st   <= H_IDLE;
			r_ff.ctrl <= CTRL_RST;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ------------------------------------------------------------
	// Pins, polarity applied per line
	// ------------------------------------------------------------
	assign BUS.cs     = r_ff.cs ? pol[POL_CS] : ~pol[POL_CS];
	assign BUS.rd_dir = (sep ? (r_ff.strb & r_ff.rd) : (r_ff.cs & r_ff.rd))
		? pol[POL_A] : ~pol[POL_A];
	assign BUS.wr_en  = (sep ? (r_ff.strb & ~r_ff.rd) : r_ff.strb)
		? pol[POL_B] : ~pol[POL_B];
	assign BUS.wide   = r_ff.wide;
	assign BUS.addr   = r_ff.addr;
	assign BUS.h_dout = r_ff.wdata;
	assign BUS.h_doe  = r_ff.doe;
	assign O_AWREADY  = ~r_ff.aw_got;
	assign O_WREADY   = ~r_ff.w_got;
	assign O_BVALID   = r_ff.bvalid;
	assign O_BRESP    = r_ff.bresp;
	assign O_ARREADY  = ~r_ff.rvalid;
	assign O_RVALID   = r_ff.rvalid;
	assign O_RDATA    = r_ff.rbus;
	assign O_RRESP    = r_ff.rresp;
endmodule
`default_nettype wire

/* File: testbench/ihb_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ihb_assertions
	import ihb_pkg::*;
(
	input  wire logic          I_CLK,
	input  wire logic          I_RST,
	input  wire logic          cs,
	input  wire logic          rd_dir,
	input  wire logic          wr_en,
	input  wire logic          wide,
	input  wire logic [15:0]   data,
	input  wire logic          d_doe,
	input  wire logic          wait_o,
	input  wire logic          wait_oe,
	input  wire logic          I_MM_MODE,
	input  wire logic          I_WAIT_EN,
	input  wire logic          I_DELAYED,
	input  wire logic          I_POSTED,
	input  wire logic          I_SEP_SIG,
	input  wire logic [3:0]    I_POL,
	input  wire logic          O_PENDING
);
	logic        cs_a;
	logic [1:0]  stb;
	logic        rd_go;
	logic        wr_go;
	logic        fl_a;
	logic        hs;

	// Pin levels turned into active flags
	assign cs_a  = cs == I_POL[POL_CS];
	assign stb   = ihb_strobes(rd_dir == I_POL[POL_A],
		wr_en == I_POL[POL_B], I_SEP_SIG);
	assign rd_go = cs_a & stb[1];
	assign wr_go = cs_a & stb[0];
	assign fl_a  = wait_oe & (wait_o == I_POL[POL_WAIT]);
	assign hs    = I_MM_MODE & I_WAIT_EN & ~O_PENDING;

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	// Flag must be seen raised before its release counts
	sequence s_up;
		##[1:4] fl_a;
	endsequence
	sequence s_rd8;
		$rose(rd_go) && hs && !wide;
	endsequence
	sequence s_np;
		$rose(wr_go) && hs && !I_POSTED;
	endsequence

	property p_cs_off; (!cs_a)[*4] |-> !wait_oe; endproperty
	property p_compat; !I_MM_MODE |-> !fl_a; endproperty
	property p_rd_up; $rose(rd_go) && hs |-> s_up; endproperty
	property p_rd8; s_rd8 and !I_DELAYED |-> s_up ##[1:43] !fl_a; endproperty
	property p_rd16;
		$rose(rd_go) && hs && wide && !I_DELAYED |-> s_up ##[1:59] !fl_a;
	endproperty
	property p_rd_dly; s_rd8 and I_DELAYED |-> s_up ##[1:47] !fl_a; endproperty
	property p_rd_data; $fell(fl_a) && rd_go |-> d_doe; endproperty
	property p_dly_data;
		$fell(fl_a) && rd_go && I_DELAYED |->
			d_doe && $past(d_doe, 3) && data == $past(data, 3);
	endproperty
	property p_pw_quiet;
		$rose(wr_go) && hs && I_POSTED |-> ##1 (!fl_a)[*6];
	endproperty
	property p_pw_pend;
		$fell(wr_go) && I_MM_MODE && I_POSTED |->
			##[1:5] (O_PENDING && (fl_a || !wait_oe));
	endproperty
	property p_np8; s_np and !wide |-> s_up ##[1:36] !fl_a; endproperty
	property p_np16; s_np and wide |-> s_up ##[1:52] !fl_a; endproperty

	a_cs_off: assert property (p_cs_off)
		else $error("stall driven while deselected");
	a_compat: assert property (p_compat)
		else $error("stall active in compatibility mode");
	a_rd_up: assert property (p_rd_up)
		else $error("stall not raised by read strobe");
	a_rd8: assert property (p_rd8)
		else $error("8-bit read release late");
	a_rd16: assert property (p_rd16)
		else $error("16-bit read release late");
	a_rd_dly: assert property (p_rd_dly)
		else $error("delayed read release late");
	a_rd_data: assert property (p_rd_data)
		else $error("read data not driven at release");
	a_dly_data: assert property (p_dly_data)
		else $error("delayed data not settled early");
	a_pw_quiet: assert property (p_pw_quiet)
		else $error("posted write stalled with none pending");
	a_pw_pend: assert property (p_pw_pend)
		else $error("posted write not marked pending");
	a_np8: assert property (p_np8)
		else $error("8-bit non-posted release wrong");
	a_np16: assert property (p_np16)
		else $error("16-bit non-posted release wrong");
endmodule
`default_nettype wire

/* File: testbench/indexed_host_bus_handshake_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module indexed_host_bus_handshake_tb_top;
	import ihb_pkg::*;
	// Mixed levels: select low, strobes high, stall low
	localparam logic [3:0] POL = 4'b0110;
	logic        I_CLK = 1'b0;
	logic        I_RST = 1'b1;
	logic [31:0] awaddr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] araddr = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        mm = 1'b1;
	logic        wen = 1'b0;
	logic        dly = 1'b0;
	logic        posted = 1'b1;
	logic        sep = 1'b0;
	logic        wr_stb, wr_wide, rd_stb, rd_wide, pend;
	logic [15:0] wr_addr, wr_data, rd_addr, rd_data;
	logic [32:0] wq[$];
	logic [16:0] rd_seen = 17'h0;
	int          n_mismatch = 0;
	int          num_checks = 0;

	always #2.5 I_CLK = ~I_CLK;
	// Device-side user answers at once, as the read port requires
	assign rd_data = rd_addr ^ 16'h5a3c;
	always @(posedge I_CLK) if (wr_stb === 1'b1)
		wq.push_back({wr_wide, wr_addr, wr_data});
	always @(posedge I_CLK) if (rd_stb === 1'b1)
		rd_seen <= {rd_wide, rd_addr};

	ihb_if u_ihb_if();
	ihb_host u_ihb_host(.I_CLK(I_CLK), .I_RST(I_RST), .BUS(u_ihb_if),
		.I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
		.I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid),
		.O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
		.I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
		.O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
		.O_RVALID(rvalid), .I_RREADY(rready));
	ihb_dev u_ihb_dev(.I_CLK(I_CLK), .I_RST(I_RST), .BUS(u_ihb_if),
		.I_MM_MODE(mm), .I_WAIT_EN(wen), .I_DELAYED(dly),
		.I_POSTED(posted), .I_SEP_SIG(sep), .I_POL(POL),
		.O_WR_STB(wr_stb), .O_WR_ADDR(wr_addr), .O_WR_DATA(wr_data),
		.O_WR_WIDE(wr_wide), .O_RD_STB(rd_stb), .O_RD_ADDR(rd_addr),
		.O_RD_WIDE(rd_wide), .I_RD_DATA(rd_data), .O_PENDING(pend));
	ihb_assertions u_ihb_assertions(.I_CLK(I_CLK), .I_RST(I_RST),
		.cs(u_ihb_if.cs), .rd_dir(u_ihb_if.rd_dir), .wr_en(u_ihb_if.wr_en),
		.wide(u_ihb_if.wide), .data(u_ihb_if.data),
		.d_doe(u_ihb_if.d_doe), .wait_o(u_ihb_if.wait_o),
		.wait_oe(u_ihb_if.wait_oe), .I_MM_MODE(mm), .I_WAIT_EN(wen),
		.I_DELAYED(dly), .I_POSTED(posted), .I_SEP_SIG(sep),
		.I_POL(POL), .O_PENDING(pend));

	// ------------------------------------------------------------
	// Bus and compare helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
			input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge I_CLK);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		@(posedge I_CLK);
		chk(bresp, er);
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
			output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge I_CLK);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge I_CLK);
	endtask

	// Pins stay put only while idle, so callers drain first
	task automatic setup(input logic m, w, dl, p, s);
		mm <= m;
		wen <= w;
		dly <= dl;
		posted <= p;
		sep <= s;
		axi_wr({28'h0, REG_CTRL}, {26'h0, POL, w, s}, RESP_OK);
	endtask

	task automatic cmd(input logic [15:0] a, input logic rd, wd,
			input logic [15:0] d);
		logic [31:0] s;
		logic [1:0]  r;
		axi_wr({28'h0, REG_WDATA}, {16'h0, d}, RESP_OK);
		axi_wr({28'h0, REG_CMD}, {14'h0, wd, rd, a}, RESP_OK);
		do axi_rd({28'h0, REG_STATUS}, s, r); while (!s[ST_DONE]);
		if (rd) chk(s[31:16], a ^ 16'h5a3c);
		if (rd) chk(rd_seen, {wd, a});
	endtask

	task automatic wr_chk(input logic [32:0] e);
		while (pend !== 1'b0) @(posedge I_CLK);
		@(posedge I_CLK);
		chk(wq.pop_front(), e);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd({28'h0, REG_CTRL}, d, r);
		chk(d, 32'h0);
		axi_rd({28'h0, REG_STATUS}, d, r);
		chk(d, 32'h0);
		axi_wr(32'h2, 32'hffff, RESP_ERR);
		axi_rd(32'h2, d, r);
		chk(r, RESP_ERR);
		chk(d, 32'h0);
		setup(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
		axi_rd({28'h0, REG_CTRL}, d, r);
		chk(d, {26'h0, POL, 2'h3});
	endtask

	task automatic t_read();
		for (int i = 0; i < 4; i++) begin
			setup(1'b1, 1'b1, 1'b0, 1'b1, i[1]);
			cmd(16'h1230 + 16'(i), 1'b1, i[0], 16'h0);
		end
		setup(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
		cmd(16'h4444, 1'b1, 1'b0, 16'h0);
	endtask

	task automatic t_posted();
		for (int i = 0; i < 2; i++) begin
			setup(1'b1, 1'b1, 1'b0, 1'b1, i[0]);
			cmd(16'h0a00, 1'b0, 1'b1, 16'hbeef);
			cmd(16'h0a02, 1'b0, 1'b0, 16'h00c3);
			cmd(16'h0b00, 1'b1, 1'b1, 16'h0);
			wr_chk({1'b1, 16'h0a00, 16'hbeef});
			wr_chk({1'b0, 16'h0a02, 16'h00c3});
		end
	endtask

	task automatic t_nonposted();
		for (int i = 0; i < 2; i++) begin
			setup(1'b1, 1'b1, 1'b0, 1'b0, i[0]);
			cmd(16'h2200 + 16'(i), 1'b0, i[0], 16'h7e81);
			wr_chk({i[0], 16'h2200 + 16'(i), 16'h7e81});
		end
	endtask

	task automatic t_modes();
		setup(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
		cmd(16'h3300, 1'b0, 1'b1, 16'h1357);
		wr_chk({1'b1, 16'h3300, 16'h1357});
		cmd(16'h3302, 1'b1, 1'b1, 16'h0);
		setup(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		cmd(16'h3400, 1'b1, 1'b1, 16'h0);
		cmd(16'h3402, 1'b0, 1'b0, 16'h0055);
		wr_chk({1'b0, 16'h3402, 16'h0055});
	endtask

	task automatic print_verdict();
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge I_CLK);
		I_RST <= 1'b0;
		t_regs();
		t_read();
		t_posted();
		t_nonposted();
		t_modes();
		print_verdict();
	end

	// About twenty bus cycles of a few hundred nanoseconds each
	initial begin
		#300000;
		n_mismatch++;
		print_verdict();
	end
endmodule
`default_nettype wire
